// ---- power_save_control.sv ----
// Purpose: power-saving control: wake detector, sleep regulator mode,
//          slowdown divider and per-module disable gates
// Assumes: APB slave, 32-bit data, single clock
// Notes:   regulator and sink are control outputs only
`default_nettype none
module power_save_control #(
    parameter int NMOD = 8
) (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_n,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // power state from the core
    input  wire logic            sleepReq,
    input  wire logic            deepSleepReq,
    input  wire logic            idleMode,
    input  wire logic            irqPending,
    input  wire logic            lowRegFuse,
    // wake sense pin
    input  wire logic            senseHigh,
    output logic                 sinkOn,
    // regulator control
    output logic                 mainRegOn,
    output logic                 mainRegStandby,
    output logic                 retRegOn,
    output logic                 sleeping,
    output logic                 wakeDone,
    // clocks enables
    output logic                 cpuClkEn,
    // peripheral gates
    output logic [NMOD-1:0]      modClkEn,
    output logic [NMOD-1:0]      modRun,
    output logic [NMOD-1:0]      modRegAccess
);
    logic [15:0]      wakeCtrl;
    logic             wakeFlag;
    logic [15:0]      resetCtrl;
    logic [15:0]      clock_divider_register;
    logic [NMOD-1:0]  modOff;
    logic [NMOD-1:0]  modEn;
    logic [NMOD-1:0]  modIdl;
    logic             wakeEvent;
    logic             cpuTick;
    logic             fullSpeed;
    logic             inDeep;
    logic [7:0]       wakeCount;
    logic             waking;
    power_save_pkg::reg_mode_t regMode;
    power_save_pkg::reg_mode_t next_regMode;

    wire logic access = psel && penable;
    wire logic wr     = access && pwrite;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wakeCtrl  <= power_save_pkg::WAKE_CTRL_RST;
            resetCtrl <= power_save_pkg::RESET_CTRL_RST;
            clock_divider_register    <= power_save_pkg::CLK_DIV_RST;
            modOff    <= '0;
            modEn     <= '1;
            modIdl    <= '0;
        end else if (wr) begin
            if (hit(paddr, power_save_pkg::OFS_WAKE_CTRL))
                wakeCtrl <= pwdata[15:0] & 16'hA100;
            if (hit(paddr, power_save_pkg::OFS_RESET_CTRL))
                resetCtrl <= pwdata[15:0] & 16'h1100;
            if (hit(paddr, power_save_pkg::OFS_CLK_DIV))
                clock_divider_register <= pwdata[15:0] & 16'hF800;
            if (hit(paddr, power_save_pkg::OFS_MOD_OFF))
                modOff <= pwdata[NMOD-1:0];
            // writes to powered-off modules are dropped
            if (hit(paddr, power_save_pkg::OFS_MOD_EN))
                modEn <= (pwdata[NMOD-1:0] & ~modOff)
                       | (modEn & modOff);
            if (hit(paddr, power_save_pkg::OFS_MOD_IDL))
                modIdl <= (pwdata[NMOD-1:0] & ~modOff)
                        | (modIdl & modOff);
        end
    end

    // wake flag: a new wake beats a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n)
            wakeFlag <= 1'b0;
        else if (wakeEvent)
            wakeFlag <= 1'b1;
        else if (wr && hit(paddr, power_save_pkg::OFS_IRQ_FLAG5))
            wakeFlag <= pwdata[power_save_pkg::WAKE_FLAG_BIT];
    end

    // apb read and answer, always zero wait states
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    power_save_pkg::OFS_WAKE_CTRL:
                        prdata <= {16'h0000, wakeCtrl};
                    power_save_pkg::OFS_IRQ_FLAG5:
                        prdata <= {31'h0, wakeFlag};
                    power_save_pkg::OFS_RESET_CTRL:
                        prdata <= {16'h0000, resetCtrl};
                    power_save_pkg::OFS_CLK_DIV:
                        prdata <= {16'h0000, clock_divider_register};
                    power_save_pkg::OFS_MOD_OFF:
                        prdata <= 32'(modOff);
                    // powered-off modules read as all ones (invalid)
                    power_save_pkg::OFS_MOD_EN:
                        prdata <= 32'(modEn | modOff);
                    power_save_pkg::OFS_MOD_IDL:
                        prdata <= 32'(modIdl | modOff);
                    power_save_pkg::OFS_STATUS:
                        prdata <= {28'h0, waking, sleeping, fullSpeed,
                                   inDeep};
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b0;
                    end
                endcase
            end
            if (psel && !penable && !hit(paddr & 8'hE3, 8'h00))
                pslverr <= 1'b1;
        end
    end

    // regulator mode selection for sleep
    always_comb begin
        if (deepSleepReq)
            next_regMode = power_save_pkg::REG_DEEP;
        else if (resetCtrl[power_save_pkg::KEEP_BIT])
            next_regMode = power_save_pkg::REG_FAST;
        else if (lowRegFuse || !resetCtrl[power_save_pkg::LOWREG_EN_BIT])
            next_regMode = power_save_pkg::REG_STANDBY;
        else
            next_regMode = power_save_pkg::REG_LOWV;
    end

    // sleep sequencer and wake latency
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sleeping  <= 1'b0;
            inDeep    <= 1'b0;
            waking    <= 1'b0;
            wakeDone  <= 1'b0;
            wakeCount <= 8'h00;
            regMode   <= power_save_pkg::REG_FAST;
        end else begin
            wakeDone <= 1'b0;
            if (!sleeping && !waking && (sleepReq || deepSleepReq)) begin
                sleeping <= 1'b1;
                inDeep   <= deepSleepReq;
                regMode  <= next_regMode;
            end else if (sleeping && (wakeEvent || irqPending)) begin
                sleeping <= 1'b0;
                waking   <= 1'b1;
                case (regMode)
                    power_save_pkg::REG_FAST:
                        wakeCount <= power_save_pkg::WAKE_LAT_FAST;
                    power_save_pkg::REG_STANDBY:
                        wakeCount <= power_save_pkg::WAKE_LAT_STANDBY;
                    // core rail must ramp back first
                    power_save_pkg::REG_LOWV:
                        wakeCount <= power_save_pkg::WAKE_LAT_LOWV;
                    power_save_pkg::REG_DEEP:
                        wakeCount <= power_save_pkg::WAKE_LAT_DEEP;
                    default:
                        wakeCount <= power_save_pkg::WAKE_LAT_DEEP;
                endcase
            end else if (waking) begin
                if (wakeCount == 8'h00) begin
                    waking   <= 1'b0;
                    inDeep   <= 1'b0;
                    wakeDone <= 1'b1;
                    regMode  <= power_save_pkg::REG_FAST;
                end else begin
                    wakeCount <= wakeCount - 8'h01;
                end
            end
        end
    end

    // regulator outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mainRegOn      <= 1'b1;
            mainRegStandby <= 1'b0;
            retRegOn       <= 1'b0;
        end else begin
            mainRegOn      <= !(sleeping &&
                (regMode == power_save_pkg::REG_LOWV ||
                 regMode == power_save_pkg::REG_DEEP));
            mainRegStandby <= sleeping &&
                regMode == power_save_pkg::REG_STANDBY;
            retRegOn       <= !lowRegFuse && sleeping &&
                regMode == power_save_pkg::REG_LOWV;
        end
    end

    // wake detector, halted in idle when asked
    wire logic wakeEn   = wakeCtrl[power_save_pkg::WAKE_EN_BIT];
    wire logic wakeHalt = wakeCtrl[power_save_pkg::WAKE_IDL_BIT] && idleMode;

    wake_detector wake_detector_inst (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .armed     (wakeEn && !wakeHalt),
        .sleeping  (sleeping && !inDeep),
        .pinHigh   (senseHigh),
        .wakeEvent (wakeEvent)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n)
            sinkOn <= 1'b0;
        else
            sinkOn <= wakeCtrl[power_save_pkg::WAKE_SINK_BIT]
                      && !wakeHalt;
    end

    // slowdown: interrupts restore full speed only when allowed
    always_ff @(posedge mclk) begin
        if (!rst_n)
            fullSpeed <= 1'b0;
        else if (!clock_divider_register[power_save_pkg::SLOW_EN_BIT])
            fullSpeed <= 1'b0;
        else if (irqPending && clock_divider_register[power_save_pkg::ROI_BIT])
            fullSpeed <= 1'b1;
    end

    doze_divider doze_divider_inst (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .active  (clock_divider_register[power_save_pkg::SLOW_EN_BIT] && !fullSpeed),
        .ratio   (clock_divider_register[power_save_pkg::RATIO_HI:
                         power_save_pkg::RATIO_LO]),
        .cpuTick (cpuTick)
    );

    // only the cpu enable is divided; module clocks ignore slowdown
    always_ff @(posedge mclk) begin
        if (!rst_n)
            cpuClkEn <= 1'b0;
        else
            cpuClkEn <= cpuTick && !sleeping && !waking;
    end

    // per-module gates
    genvar g;
    generate
        for (g = 0; g < NMOD; g++) begin : gMod
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    modClkEn[g]     <= 1'b0;
                    modRun[g]       <= 1'b0;
                    modRegAccess[g] <= 1'b0;
                end else begin
                    modClkEn[g]     <= !modOff[g];
                    modRegAccess[g] <= !modOff[g];
                    modRun[g]       <= !modOff[g] && modEn[g]
                        && !(modIdl[g] && idleMode);
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- power_save_pkg.sv ----
// Purpose: shared constants for the power-save control block
// Assumes: 32-bit APB register map, word aligned
// Notes:   offsets not printed are chosen here
`default_nettype none
package power_save_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_WAKE_CTRL   = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAG5   = 8'h04;
    localparam logic [7:0] OFS_RESET_CTRL  = 8'h08;
    localparam logic [7:0] OFS_CLK_DIV     = 8'h0C;
    localparam logic [7:0] OFS_MOD_OFF     = 8'h10;
    localparam logic [7:0] OFS_MOD_EN      = 8'h14;
    localparam logic [7:0] OFS_MOD_IDL     = 8'h18;
    localparam logic [7:0] OFS_STATUS      = 8'h1C;
    // wake control fields
    localparam int WAKE_EN_BIT    = 15;
    localparam int WAKE_IDL_BIT   = 13;
    localparam int WAKE_SINK_BIT  = 8;
    // irq flag register 5
    localparam int WAKE_FLAG_BIT  = 0;
    // reset control fields
    localparam int LOWREG_EN_BIT  = 12;
    localparam int KEEP_BIT       = 8;
    // clock divider fields
    localparam int ROI_BIT        = 15;
    localparam int RATIO_HI       = 14;
    localparam int RATIO_LO       = 12;
    localparam int SLOW_EN_BIT    = 11;
    // reset values
    localparam logic [15:0] WAKE_CTRL_RST = 16'h0000;
    localparam logic [15:0] RESET_CTRL_RST = 16'h0000;
    localparam logic [15:0] CLK_DIV_RST   = 16'h0000;
    localparam logic [2:0]  RATIO_RST     = 3'h0;
    // regulator modes during sleep
    typedef enum logic [1:0] {
        REG_FAST, REG_STANDBY, REG_LOWV, REG_DEEP
    } reg_mode_t;
    // wake latency in cycles per mode
    localparam logic [7:0] WAKE_LAT_FAST    = 8'h02;
    localparam logic [7:0] WAKE_LAT_STANDBY = 8'h08;
    localparam logic [7:0] WAKE_LAT_LOWV    = 8'h20;
    localparam logic [7:0] WAKE_LAT_DEEP    = 8'hFF;
endpackage
`default_nettype wire

// ---- doze_divider.sv ----
// Purpose: cpu clock-enable divider for slowdown mode
// Assumes: ratio code n divides by two to the n
// Notes:   enable pulses stay aligned to the peripheral clock
`default_nettype none
module doze_divider (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // control
    input  wire logic       active,
    input  wire logic [2:0] ratio,
    // cpu clock enable
    output logic            cpuTick
);
    logic [6:0] count;
    logic [6:0] limit;

    // code n maps to divisor 2**n; one tick per divisor periods
    always_comb begin
        limit = 7'((8'h01 << ratio) - 8'h01);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count   <= 7'h00;
            cpuTick <= 1'b0;
        end else if (!active || count >= limit) begin
            count   <= 7'h00;
            cpuTick <= 1'b1;
        end else begin
            count   <= count + 7'h01;
            cpuTick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- wake_detector.sv ----
// Purpose: falling-threshold wake detector on the sense pin
// Assumes: pin level is already a digital compare against low threshold
// Notes:   arms only while sleeping with enable set
`default_nettype none
module wake_detector (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // state
    input  wire logic armed,
    input  wire logic sleeping,
    input  wire logic pinHigh,
    // event
    output logic      wakeEvent
);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wakeEvent <= 1'b0;
        end else begin
            // level below threshold, so a pin already low also wakes
            wakeEvent <= armed && sleeping && !pinHigh;
        end
    end
endmodule
`default_nettype wire

// ---- rc_wake_network.sv ----
// Purpose: behavioural resistor-capacitor network on the wake sense pin
// Assumes: level is a cycle count, compared against the low threshold
// Notes:   discharges only while the sink is on, charge wins over sink
`default_nettype none
module rc_wake_network #(
    parameter int FULL = 60,
    parameter int THR  = 10
) (
    // clock
    input  wire logic mclk,
    // pin drive and sink
    input  wire logic charge,
    input  wire logic sinkOn,
    // threshold compare
    output logic      senseHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    int level = 0;
    // pin driven high as an output charges the capacitor
    always @(posedge mclk) begin
        if (charge) begin
            level <= FULL;
        end else if (sinkOn && level > 0) begin
            level <= level - 1;
        end
    end
    assign senseHigh = level > THR;
endmodule
`default_nettype wire

// ---- power_save_control_chk.sv ----
// Purpose: port-level checker for the power-save control block
// Assumes: register writes are mirrored from the apb access phase
// Notes:   regulator checks skip the first sleep cycle while modes land
`default_nettype none
module power_save_control_chk #(
    parameter int NMOD = 8
) (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_n,
    // apb
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic            pready,
    // power state
    input  wire logic            sleepReq,
    input  wire logic            deepSleepReq,
    input  wire logic            idleMode,
    input  wire logic            lowRegFuse,
    input  wire logic            sinkOn,
    input  wire logic            mainRegOn,
    input  wire logic            mainRegStandby,
    input  wire logic            retRegOn,
    input  wire logic            sleeping,
    input  wire logic            wakeDone,
    // module gates
    input  wire logic [NMOD-1:0] modClkEn,
    input  wire logic [NMOD-1:0] modRun,
    input  wire logic [NMOD-1:0] modRegAccess
);
    timeunit 1ns;
    timeprecision 1ps;
    logic            wr;
    logic            keep;
    logic            lowEn;
    logic            deep;
    logic [NMOD-1:0] idl;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    assign wr = psel && penable && pwrite && pready;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            keep <= 1'b0;
            lowEn <= 1'b0;
        end else if (wr && paddr == power_save_pkg::OFS_RESET_CTRL) begin
            keep <= pwdata[8];
            lowEn <= pwdata[12];
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            idl <= '0;
        end else if (wr && paddr == power_save_pkg::OFS_MOD_IDL) begin
            idl <= pwdata[NMOD-1:0];
        end
    end
    // deep request is only taken while awake
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            deep <= 1'b0;
        end else if (!sleeping) begin
            deep <= deepSleepReq;
        end
    end
    sequence s_asleep;
        sleeping && $past(sleeping) && !deep;
    endsequence
    sequence s_wakeStart;
        $fell(sleeping);
    endsequence
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_sink_follows: assert property (
        wr && paddr == power_save_pkg::OFS_WAKE_CTRL |-> ##2
        sinkOn == ($past(pwdata[8], 2) && !($past(pwdata[13], 2)
        && $past(idleMode)))) else $error("sink mismatch");
    a_keep_fast: assert property ((s_asleep ##0 keep) |->
        mainRegOn && !mainRegStandby && !retRegOn)
        else $error("keep not fast");
    a_standby_mode: assert property (
        (s_asleep ##0 (!keep && (!lowEn || lowRegFuse)))
        |-> mainRegStandby && !retRegOn) else $error("not standby");
    a_retention_mode: assert property (
        (s_asleep ##0 (!keep && lowEn && !lowRegFuse))
        |-> retRegOn && !mainRegOn) else $error("not retention");
    a_fuse_blocks: assert property (
        lowRegFuse && $past(lowRegFuse) |-> !retRegOn)
        else $error("retention with fuse");
    a_deep_off: assert property (
        sleeping && $past(sleeping) && deep |-> !mainRegOn && !retRegOn)
        else $error("regulator on in deep");
    a_off_no_access: assert property ((modRegAccess & ~modClkEn) == '0)
        else $error("access while off");
    a_run_needs_clk: assert property ((modRun & ~modClkEn) == '0)
        else $error("run without clock");
    a_idle_stops: assert property (
        idleMode [*3] |-> (modRun & idl) == '0) else $error("runs in idle");
    a_wake_done: assert property (
        s_wakeStart |-> ##[1:260] wakeDone) else $error("wake never done");
    a_sleep_taken: assert property (
        $rose(sleeping) |-> $past(sleepReq) || $past(deepSleepReq))
        else $error("sleep without request");
    a_done_pulse: assert property (wakeDone |=> !wakeDone)
        else $error("done too long");
endmodule
`default_nettype wire

// ---- power_save_control_bench.sv ----
// Purpose: self-checking bench for the power-save control block
// Assumes: zero-wait apb slave, wake by pin or pending interrupt
// Notes:   latencies are compared by order only, their values are free
`default_nettype none
module power_save_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic rdErr;
    logic pready, pslverr, sleepReq = 0, deepSleepReq = 0, idleMode = 0;
    logic irqPending = 0, lowRegFuse = 0, senseHigh, sinkOn, charge = 0;
    logic mainRegOn, mainRegStandby, retRegOn, sleeping, wakeDone, cpuClkEn;
    logic [7:0] modClkEn, modRun, modRegAccess;
    int n_errors = 0, num_checks = 0, c, lat[4];
    power_save_control #(.NMOD(8)) power_save_control_inst (.mclk, .rst_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sleepReq, .deepSleepReq, .idleMode, .irqPending,
        .lowRegFuse, .senseHigh, .sinkOn, .mainRegOn, .mainRegStandby,
        .retRegOn, .sleeping, .wakeDone, .cpuClkEn, .modClkEn, .modRun,
        .modRegAccess);
    rc_wake_network rc_wake_network_inst (.mclk, .charge, .sinkOn,
        .senseHigh);
    initial begin
        forever #4 mclk = ~mclk;
    end
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        rdErr = pslverr;
        check(32'(k < 50), 32'h1);
        psel <= 0;
        penable <= 0;
    endtask
    task wait_done;
        int k;
        k = 0;
        while (wakeDone !== 1'b1 && k < 1000) begin
            @(posedge mclk);
            k++;
        end
        check(32'(k < 1000), 32'h1);
    endtask
    task ticks(input int len);
        c = 0;
        repeat (len) begin
            @(posedge mclk);
            if (cpuClkEn === 1'b1) c++;
        end
    endtask
    task nap(input logic [31:0] rc, input logic f, input logic dp,
             input logic [1:0] exp, output int l);
        apb(1, power_save_pkg::OFS_RESET_CTRL, rc);
        lowRegFuse <= f;
        if (dp) deepSleepReq <= 1; else sleepReq <= 1;
        @(posedge mclk);
        sleepReq <= 0;
        deepSleepReq <= 0;
        repeat (4) @(posedge mclk);
        check(32'(sleeping), 32'h1);
        check(32'({mainRegStandby, retRegOn}), 32'(exp));
        irqPending <= 1;
        l = 0;
        while (wakeDone !== 1'b1 && l < 1000) begin
            @(posedge mclk);
            l++;
        end
        check(32'(l < 1000), 32'h1);
        irqPending <= 0;
        lowRegFuse <= 0;
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1;
        apb(0, power_save_pkg::OFS_WAKE_CTRL, 0);
        check(rd, 32'h0);
        apb(0, power_save_pkg::OFS_CLK_DIV, 0);
        check(rd, 32'h0);
        apb(0, power_save_pkg::OFS_MOD_EN, 0);
        check(rd, 32'hFF);
        apb(0, 8'h20, 0);
        check({rd[30:0], rdErr}, 32'h1);
        $display("test reset values done");
        charge <= 1;
        repeat (20) @(posedge mclk);
        charge <= 0;
        apb(1, power_save_pkg::OFS_WAKE_CTRL, 32'h8100);
        repeat (2) @(posedge mclk);
        check(32'(sinkOn), 32'h1);
        apb(1, power_save_pkg::OFS_IRQ_FLAG5, 0);
        sleepReq <= 1;
        @(posedge mclk);
        sleepReq <= 0;
        wait_done;
        apb(0, power_save_pkg::OFS_IRQ_FLAG5, 0);
        check(rd, 32'h1);
        apb(1, power_save_pkg::OFS_IRQ_FLAG5, 0);
        apb(0, power_save_pkg::OFS_IRQ_FLAG5, 0);
        check(rd, 32'h0);
        apb(1, power_save_pkg::OFS_WAKE_CTRL, 32'h2100);
        idleMode <= 1;
        repeat (2) @(posedge mclk);
        check(32'(sinkOn), 32'h0);
        idleMode <= 0;
        apb(1, power_save_pkg::OFS_WAKE_CTRL, 0);
        repeat (2) @(posedge mclk);
        check(32'(sinkOn), 32'h0);
        $display("test pin wake done");
        nap(32'h0100, 0, 0, 2'b00, lat[0]);
        nap(32'h0000, 0, 0, 2'b10, lat[1]);
        nap(32'h1000, 0, 0, 2'b01, lat[2]);
        nap(32'h0000, 0, 1, 2'b00, lat[3]);
        nap(32'h1000, 1, 0, 2'b10, c);
        check(32'(lat[1] > lat[0]), 32'h1);
        check(32'(lat[2] > lat[1]), 32'h1);
        check(32'(lat[3] > lat[2] && lat[3] < 1000), 32'h1);
        $display("test regulator modes done");
        for (int n = 0; n < 8; n++) begin
            apb(1, power_save_pkg::OFS_CLK_DIV, 32'h0800 | (n << 12));
            repeat (4) @(posedge mclk);
            ticks(256);
            check(c, 256 >> n);
        end
        apb(1, power_save_pkg::OFS_CLK_DIV, 32'hB800);
        irqPending <= 1;
        @(posedge mclk);
        irqPending <= 0;
        repeat (4) @(posedge mclk);
        ticks(16);
        check(c, 16);
        apb(1, power_save_pkg::OFS_CLK_DIV, 0);
        apb(1, power_save_pkg::OFS_CLK_DIV, 32'h3800);
        irqPending <= 1;
        @(posedge mclk);
        irqPending <= 0;
        repeat (4) @(posedge mclk);
        ticks(16);
        check(c, 2);
        $display("test slowdown done");
        apb(1, power_save_pkg::OFS_MOD_OFF, 32'h1);
        apb(1, power_save_pkg::OFS_MOD_EN, 32'hFC);
        apb(0, power_save_pkg::OFS_MOD_EN, 0);
        check(rd, 32'hFD);
        check(32'({modClkEn[0], modRegAccess[0]}), 32'h0);
        check(32'({modRun[1], modClkEn[1], modRegAccess[1]}), 32'h3);
        apb(1, power_save_pkg::OFS_MOD_IDL, 32'h4);
        idleMode <= 1;
        repeat (4) @(posedge mclk);
        check(32'({modRun[2], modRun[3]}), 32'h1);
        idleMode <= 0;
        repeat (4) @(posedge mclk);
        check(32'(modRun[2]), 32'h1);
        $display("test module gates done");
        give_verdict;
    end
endmodule
bind power_save_control power_save_control_chk #(.NMOD(NMOD))
    power_save_control_chk_inst (.mclk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .sleepReq, .deepSleepReq, .idleMode,
    .lowRegFuse, .sinkOn, .mainRegOn, .mainRegStandby, .retRegOn,
    .sleeping, .wakeDone, .modClkEn, .modRun, .modRegAccess);
`default_nettype wire
